// ### inc/sensor_offset_consts.svh
`ifndef SENSOR_OFFSET_CONSTS_SVH
`define SENSOR_OFFSET_CONSTS_SVH
// ----------------------------------------
// register map (word offsets)
// ----------------------------------------
`define SOS_ADDR_W          4
`define SOS_REG_DISTANCE    4'h0
`define SOS_REG_VELOCITY    4'h1
`define SOS_REG_POS_LIMIT   4'h2
`define SOS_REG_VEL_LIMIT   4'h3
`define SOS_REG_CONTROL     4'h4
`define SOS_REG_STATUS      4'h5
`define SOS_REG_LATCH_POS   4'h6
`define SOS_REG_NV_DIST     4'h7
// ----------------------------------------
// fields and values
// ----------------------------------------
`define SOS_DATA_W          32
`define SOS_CTL_SAVE_BIT    0
`define SOS_ACTION_W        2
`define SOS_ACTION_OFFSET   2'h2
`define SOS_DIST_FACTORY    32'h0000_0000
`define SOS_VEL_FACTORY     32'h0000_03E8
`define SOS_VEL_MIN         32'h0000_0001
`define SOS_POS_LIMIT_RST   32'h7FFF_FFFF
`define SOS_VEL_LIMIT_RST   32'h000F_4240
`endif

// ### inc/sensor_offset_pkg.sv
package sensor_offset_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RUN,
    ST_OFFSET,
    ST_DECEL,
    ST_DONE
  } motion_state_t;
endpackage

// ### rtl/sensor_offset_stop.sv
// Notes on behaviour
// - offset distance accepts 0 up to the position limit and can be read and written.
// - a written offset distance is used by motion control from the next cycle.
// - at power up the offset distance is loaded from the last saved copy.
// - with nothing ever saved the offset distance starts at zero.
// - in a continuous move with offset mode the axis stops the offset distance past the sensor.
// - on sensor detection speed changes to the offset velocity, then decelerates to rest.
// - offset velocity accepts 0.001 up to the velocity limit and takes effect from the next cycle.
`include "sensor_offset_consts.svh"
module sensor_offset_stop
(
  // clock and reset
  input  wire logic                       CLK_I,
  input  wire logic                       RST_I,
  // register port
  input  wire logic [`SOS_ADDR_W-1:0]     ADDR_I,
  input  wire logic [`SOS_DATA_W-1:0]     WDATA_I,
  input  wire logic                       WR_I,
  input  wire logic                       RD_I,
  output logic      [`SOS_DATA_W-1:0]     RDATA_O,
  // nonvolatile copy of the distance
  input  wire logic                       NV_VALID_I,
  input  wire logic [`SOS_DATA_W-1:0]     NV_DIST_I,
  output logic                            NV_SAVE_O,
  output logic      [`SOS_DATA_W-1:0]     NV_DATA_O,
  // motion side
  input  wire logic                       MOVE_POS_I,
  input  wire logic                       MOVE_NEG_I,
  input  wire logic [`SOS_ACTION_W-1:0]   ACTION_SEL_I,
  input  wire logic                       SENSOR_ASSIGNED_I,
  input  wire logic                       SENSOR_I,
  input  wire logic signed [`SOS_DATA_W-1:0] AXIS_POS_I,
  input  wire logic                       AXIS_STOPPED_I,
  output logic                            SPEED_CHANGE_O,
  output logic      [`SOS_DATA_W-1:0]     SPEED_O,
  output logic                            DECEL_STOP_O,
  output logic                            OFFSET_DONE_O
);

  // ----------------------------------------
  // sensor synchroniser
  // ----------------------------------------
  logic sens_m_q;
  logic sens_s_q;
  logic sens_p_q;
  logic sens_m_d;
  logic sens_s_d;
  logic sens_p_d;

  always_comb
  begin
    sens_m_d = SENSOR_I;
    sens_s_d = sens_m_q;
    sens_p_d = sens_s_q;
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      sens_m_q <= 1'b0;
      sens_s_q <= 1'b0;
      sens_p_q <= 1'b0;
    end
    else
    begin
      sens_m_q <= sens_m_d;
      sens_s_q <= sens_s_d;
      sens_p_q <= sens_p_d;
    end
  end

  wire logic sens_rise = sens_s_q & ~sens_p_q;

  // ----------------------------------------
  // parameters
  // ----------------------------------------
  logic [`SOS_DATA_W-1:0] dist_q;
  logic [`SOS_DATA_W-1:0] dist_d;
  logic [`SOS_DATA_W-1:0] vel_q;
  logic [`SOS_DATA_W-1:0] vel_d;
  logic [`SOS_DATA_W-1:0] plim_q;
  logic [`SOS_DATA_W-1:0] plim_d;
  logic [`SOS_DATA_W-1:0] vlim_q;
  logic [`SOS_DATA_W-1:0] vlim_d;
  logic                   boot_q;
  logic                   boot_d;
  logic                   save_q;
  logic                   save_d;
  logic [`SOS_DATA_W-1:0] rdata_q;
  logic [`SOS_DATA_W-1:0] rdata_d;

  // ----------------------------------------
  // motion state
  // ----------------------------------------
  sensor_offset_pkg::motion_state_t st_q;
  sensor_offset_pkg::motion_state_t st_d;
  logic [`SOS_DATA_W-1:0] latch_q;
  logic [`SOS_DATA_W-1:0] latch_d;
  logic [`SOS_DATA_W-1:0] stop_dist_q;
  logic [`SOS_DATA_W-1:0] stop_dist_d;
  logic                   chg_q;
  logic                   chg_d;
  logic                   decel_q;
  logic                   decel_d;
  logic                   done_q;
  logic                   done_d;
  logic                   dir_neg_q;
  logic                   dir_neg_d;

  wire logic wr_hit_dist = WR_I && (ADDR_I == `SOS_REG_DISTANCE);

  logic [`SOS_DATA_W-1:0] travelled;
  logic                   offset_ok;
  logic                   moving;

  always_comb
  begin
    dist_d  = dist_q;
    vel_d   = vel_q;
    plim_d  = plim_q;
    vlim_d  = vlim_q;
    boot_d  = 1'b0;
    save_d  = 1'b0;
    rdata_d = '0;
    // saved copy replaces runtime value once, right after reset
    if (boot_q)
    begin
      dist_d = NV_VALID_I ? NV_DIST_I : `SOS_DIST_FACTORY;
    end
    else if (WR_I)
    begin
      case (ADDR_I)
        // out-of-range writes are dropped, old value stays
        `SOS_REG_DISTANCE:
          if (WDATA_I <= plim_q)
            dist_d = WDATA_I;
        `SOS_REG_VELOCITY:
          if (WDATA_I >= `SOS_VEL_MIN && WDATA_I <= vlim_q)
            vel_d = WDATA_I;
        `SOS_REG_POS_LIMIT: plim_d = WDATA_I;
        `SOS_REG_VEL_LIMIT: vlim_d = WDATA_I;
        `SOS_REG_CONTROL:   save_d = WDATA_I[`SOS_CTL_SAVE_BIT];
        default: ;
      endcase
    end
    if (RD_I)
    begin
      case (ADDR_I)
        `SOS_REG_DISTANCE:  rdata_d = dist_q;
        `SOS_REG_VELOCITY:  rdata_d = vel_q;
        `SOS_REG_POS_LIMIT: rdata_d = plim_q;
        `SOS_REG_VEL_LIMIT: rdata_d = vlim_q;
        `SOS_REG_STATUS:    rdata_d = {28'h0, offset_ok, (st_q == sensor_offset_pkg::ST_DONE),
                                       decel_q, chg_q};
        `SOS_REG_LATCH_POS: rdata_d = latch_q;
        `SOS_REG_NV_DIST:   rdata_d = NV_VALID_I ? NV_DIST_I : `SOS_DIST_FACTORY;
        default:            rdata_d = '0;
      endcase
    end
  end

  always_comb
  begin
    offset_ok   = (ACTION_SEL_I == `SOS_ACTION_OFFSET) && SENSOR_ASSIGNED_I;
    moving      = MOVE_POS_I ^ MOVE_NEG_I;
    travelled   = dir_neg_q ? (latch_q - AXIS_POS_I) : (AXIS_POS_I - latch_q);
    st_d        = st_q;
    latch_d     = latch_q;
    stop_dist_d = stop_dist_q;
    dir_neg_d   = dir_neg_q;
    chg_d       = 1'b0;
    decel_d     = decel_q;
    done_d      = 1'b0;
    case (st_q)
      sensor_offset_pkg::ST_IDLE:
        if (moving && offset_ok)
        begin
          dir_neg_d = MOVE_NEG_I;
          st_d      = sensor_offset_pkg::ST_RUN;
        end
      sensor_offset_pkg::ST_RUN:
        if (!moving)
          st_d = sensor_offset_pkg::ST_IDLE;
        else if (sens_rise)
        begin
          latch_d     = AXIS_POS_I;
          stop_dist_d = wr_hit_dist && WDATA_I <= plim_q ? WDATA_I : dist_q;
          chg_d       = 1'b1;
          st_d        = sensor_offset_pkg::ST_OFFSET;
        end
      sensor_offset_pkg::ST_OFFSET:
      begin
        // distance written mid-move still counts at once
        if (dist_d != dist_q)
          stop_dist_d = dist_d;
        // a move dropped before the target abandons the offset stop, else it hangs here
        if (!moving)
          st_d = sensor_offset_pkg::ST_IDLE;
        else if (travelled >= stop_dist_q)
        begin
          decel_d = 1'b1;
          st_d    = sensor_offset_pkg::ST_DECEL;
        end
      end
      sensor_offset_pkg::ST_DECEL:
        if (AXIS_STOPPED_I)
        begin
          decel_d = 1'b0;
          done_d  = 1'b1;
          st_d    = sensor_offset_pkg::ST_DONE;
        end
      sensor_offset_pkg::ST_DONE:
        if (!moving)
          st_d = sensor_offset_pkg::ST_IDLE;
      default:
        st_d = sensor_offset_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      dist_q      <= `SOS_DIST_FACTORY;
      vel_q       <= `SOS_VEL_FACTORY;
      plim_q      <= `SOS_POS_LIMIT_RST;
      vlim_q      <= `SOS_VEL_LIMIT_RST;
      boot_q      <= 1'b1;
      save_q      <= 1'b0;
      rdata_q     <= '0;
      st_q        <= sensor_offset_pkg::ST_IDLE;
      latch_q     <= '0;
      stop_dist_q <= '0;
      chg_q       <= 1'b0;
      decel_q     <= 1'b0;
      done_q      <= 1'b0;
      dir_neg_q   <= 1'b0;
    end
    else
    begin
      dist_q      <= dist_d;
      vel_q       <= vel_d;
      plim_q      <= plim_d;
      vlim_q      <= vlim_d;
      boot_q      <= boot_d;
      save_q      <= save_d;
      rdata_q     <= rdata_d;
      st_q        <= st_d;
      latch_q     <= latch_d;
      stop_dist_q <= stop_dist_d;
      chg_q       <= chg_d;
      decel_q     <= decel_d;
      done_q      <= done_d;
      dir_neg_q   <= dir_neg_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign RDATA_O        = rdata_q;
  assign NV_SAVE_O      = save_q;
  assign NV_DATA_O      = dist_q;
  assign SPEED_CHANGE_O = chg_q;
  assign SPEED_O        = vel_q;
  assign DECEL_STOP_O   = decel_q;
  assign OFFSET_DONE_O  = done_q;

endmodule

// ### verification/axis_model.sv
module axis_model
#(
  parameter int STOP_CYC = 3
)
(
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  input  wire logic   move_pos_i,
  input  wire logic   move_neg_i,
  input  wire logic   speed_change_i,
  input  wire logic   decel_i,
  output logic signed [31:0] pos_o,
  output logic        stopped_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic slow_q;
  int   cnt_q;
  // slow after the speed change so the overshoot past the target stays small
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (!move_pos_i && !move_neg_i))
    begin
      slow_q    <= 1'b0;
      stopped_o <= 1'b0;
      cnt_q     <= 0;
      if (rst_i)
        pos_o <= '0;
    end
    else
    begin
      if (speed_change_i)
        slow_q <= 1'b1;
      if (!stopped_o)
        pos_o <= move_neg_i ? pos_o - (slow_q ? 1 : 4) : pos_o + (slow_q ? 1 : 4);
      cnt_q <= decel_i ? cnt_q + 1 : 0;
      if (decel_i && cnt_q >= STOP_CYC)
        stopped_o <= 1'b1;
    end
  end
endmodule

// ### verification/sensor_offset_stop_properties.sv
`include "sensor_offset_consts.svh"
module sos_properties
(
  // watched ports
  input wire logic                   CLK_I,
  input wire logic                   RST_I,
  input wire logic [`SOS_ADDR_W-1:0] ADDR_I,
  input wire logic [`SOS_DATA_W-1:0] WDATA_I,
  input wire logic                   WR_I,
  input wire logic                   RD_I,
  input wire logic [`SOS_DATA_W-1:0] RDATA_O,
  input wire logic                   NV_SAVE_O,
  input wire logic [`SOS_DATA_W-1:0] NV_DATA_O,
  input wire logic [`SOS_DATA_W-1:0] SPEED_O,
  input wire logic                   AXIS_STOPPED_I,
  input wire logic                   SPEED_CHANGE_O,
  input wire logic                   DECEL_STOP_O,
  input wire logic                   OFFSET_DONE_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  rd_idle_a: assert property (!$past(RD_I) |-> RDATA_O == '0)
    else $error("read data not idle");
  // the saved copy may only move after a distance write or the power-up load
  dist_src_a: assert property ($changed(NV_DATA_O) |->
    ($past(WR_I) && $past(ADDR_I) == `SOS_REG_DISTANCE) || $past(RST_I, 2))
    else $error("distance changed without a write");
  save_req_a: assert property (WR_I && ADDR_I == `SOS_REG_CONTROL
    && WDATA_I[`SOS_CTL_SAVE_BIT] |=> NV_SAVE_O) else $error("save not requested");
  vel_zero_a: assert property (WR_I && ADDR_I == `SOS_REG_VELOCITY
    && WDATA_I == '0 |=> $stable(SPEED_O)) else $error("zero velocity taken");
  sc_pulse_a: assert property (SPEED_CHANGE_O |=> !SPEED_CHANGE_O)
    else $error("speed change too long");
  decel_hold_a: assert property (DECEL_STOP_O && !AXIS_STOPPED_I |=> DECEL_STOP_O)
    else $error("decel dropped early");
  decel_end_a: assert property (DECEL_STOP_O && AXIS_STOPPED_I
    |=> !DECEL_STOP_O && OFFSET_DONE_O) else $error("stop not completed");
  done_pulse_a: assert property (OFFSET_DONE_O |=> !OFFSET_DONE_O)
    else $error("done too long");
  cover property (SPEED_CHANGE_O);
  cover property (OFFSET_DONE_O);
  cover property (NV_SAVE_O);
endmodule
bind sensor_offset_stop sos_properties i_sos_properties (.CLK_I(CLK_I), .RST_I(RST_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .NV_SAVE_O(NV_SAVE_O), .NV_DATA_O(NV_DATA_O), .SPEED_O(SPEED_O),
  .AXIS_STOPPED_I(AXIS_STOPPED_I), .SPEED_CHANGE_O(SPEED_CHANGE_O),
  .DECEL_STOP_O(DECEL_STOP_O), .OFFSET_DONE_O(OFFSET_DONE_O));

// ### verification/tb_sensor_offset_stop.sv
`include "sensor_offset_consts.svh"
module tb_sensor_offset_stop;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_I = 0, RST_I = 1, WR_I = 0, RD_I = 0, NV_VALID_I = 1, SENSOR_I = 0;
  logic MOVE_POS_I = 0, MOVE_NEG_I = 0, SENSOR_ASSIGNED_I = 1;
  logic [1:0] ACTION_SEL_I = 2'h2;
  logic [3:0] ADDR_I = 4'h0;
  logic [31:0] WDATA_I = 32'h0, NV_DIST_I = 32'h20, RDATA_O, NV_DATA_O, SPEED_O, v;
  logic signed [31:0] AXIS_POS_I, at_decel, d;
  logic AXIS_STOPPED_I, NV_SAVE_O, SPEED_CHANGE_O, DECEL_STOP_O, OFFSET_DONE_O;
  int err_total = 0, samples_checked = 0, cycles = 0;
  always #4 CLK_I = ~CLK_I;
  sensor_offset_stop i_sensor_offset_stop (.CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .NV_VALID_I(NV_VALID_I), .NV_DIST_I(NV_DIST_I), .NV_SAVE_O(NV_SAVE_O),
    .NV_DATA_O(NV_DATA_O), .MOVE_POS_I(MOVE_POS_I), .MOVE_NEG_I(MOVE_NEG_I),
    .ACTION_SEL_I(ACTION_SEL_I), .SENSOR_ASSIGNED_I(SENSOR_ASSIGNED_I),
    .SENSOR_I(SENSOR_I), .AXIS_POS_I(AXIS_POS_I), .AXIS_STOPPED_I(AXIS_STOPPED_I),
    .SPEED_CHANGE_O(SPEED_CHANGE_O), .SPEED_O(SPEED_O), .DECEL_STOP_O(DECEL_STOP_O),
    .OFFSET_DONE_O(OFFSET_DONE_O));
  axis_model i_axis_model (.clk_i(CLK_I), .rst_i(RST_I), .move_pos_i(MOVE_POS_I),
    .move_neg_i(MOVE_NEG_I), .speed_change_i(SPEED_CHANGE_O), .decel_i(DECEL_STOP_O),
    .pos_o(AXIS_POS_I), .stopped_o(AXIS_STOPPED_I));
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] dat);
    @(posedge CLK_I);
    WR_I <= 1'b1;
    ADDR_I <= a;
    WDATA_I <= dat;
    @(posedge CLK_I);
    WR_I <= 1'b0;
  endtask
  task automatic rd_get(input logic [3:0] a);
    @(posedge CLK_I);
    RD_I <= 1'b1;
    ADDR_I <= a;
    @(posedge CLK_I);
    RD_I <= 1'b0;
    #1 v = RDATA_O;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    rd_get(a);
    check(v, exp);
  endtask
  task automatic do_reset(input logic valid);
    NV_VALID_I <= valid;
    RST_I <= 1'b1;
    repeat (2) @(posedge CLK_I);
    RST_I <= 1'b0;
    repeat (2) @(posedge CLK_I);
  endtask
  // the latched position is not known in advance, only its distance to the decel point
  task automatic move(input logic neg, input logic [1:0] act);
    ACTION_SEL_I <= act;
    MOVE_NEG_I <= neg;
    MOVE_POS_I <= !neg;
    repeat (4) @(posedge CLK_I);
    SENSOR_I <= 1'b1;
    if (act == `SOS_ACTION_OFFSET)
    begin
      @(posedge DECEL_STOP_O);
      #1 at_decel = AXIS_POS_I;
      @(posedge OFFSET_DONE_O);
      rd(`SOS_REG_STATUS, 32'h0000_000C);
    end
    else
    begin
      repeat (12)
      begin
        @(posedge CLK_I);
        #1 check({31'h0, SPEED_CHANGE_O}, 32'h0);
      end
      rd(`SOS_REG_STATUS, 32'h0000_0000);
    end
    @(posedge CLK_I);
    MOVE_POS_I <= 1'b0;
    MOVE_NEG_I <= 1'b0;
    SENSOR_I <= 1'b0;
    if (act == `SOS_ACTION_OFFSET)
    begin
      rd_get(`SOS_REG_LATCH_POS);
      d = neg ? v - at_decel : at_decel - v;
      check({31'h0, d >= 16 && d <= 18}, 32'h1);
    end
    $display("test move done");
  endtask
  always @(posedge CLK_I)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      test_done();
    end
  end
  initial
  begin
    do_reset(1'b1);
    rd(`SOS_REG_DISTANCE, 32'h20);
    rd(`SOS_REG_NV_DIST, 32'h20);
    do_reset(1'b0);
    rd(`SOS_REG_DISTANCE, 32'h0);
    rd(`SOS_REG_VEL_LIMIT, 32'h000F_4240);
    rd(`SOS_REG_VELOCITY, 32'h3E8);
    wr(`SOS_REG_POS_LIMIT, 32'h100);
    wr(`SOS_REG_DISTANCE, 32'h101);
    rd(`SOS_REG_DISTANCE, 32'h0);
    wr(`SOS_REG_DISTANCE, 32'h100);
    rd(`SOS_REG_DISTANCE, 32'h100);
    wr(`SOS_REG_VELOCITY, 32'h0);
    rd(`SOS_REG_VELOCITY, 32'h3E8);
    wr(`SOS_REG_VELOCITY, 32'h1);
    rd(`SOS_REG_VELOCITY, 32'h1);
    check(SPEED_O, 32'h1);
    wr(`SOS_REG_CONTROL, 32'h1);
    #1 check({31'h0, NV_SAVE_O}, 32'h1);
    check(NV_DATA_O, 32'h100);
    rd(4'h8, 32'h0);
    $display("test registers done");
    wr(`SOS_REG_DISTANCE, 32'h10);
    move(1'b0, 2'h2);
    move(1'b1, 2'h2);
    move(1'b0, 2'h1);
    test_done();
  end
endmodule
